/* gtp_asserts.sv */
// gtp_asserts: bus handshake and pin relations of gtp_top.
// assumes ce is held high and a single mclk domain.
`timescale 1ns/1ps
`default_nettype none
module gtp_asserts (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic timer_waveform_output, // pin
  input wire logic timer_waveform_output_oe_n, // oe
  input wire logic pwm_output_one, // pin
  input wire logic pwm_output_one_oe_n, // oe
  input wire logic pwm_output_two, // pin
  input wire logic pwm_output_two_oe_n, // oe
  input wire logic pwm_output_three, // pin
  input wire logic pwm_output_three_oe_n, // oe
  input wire logic pwm_output_four, // pin
  input wire logic pwm_output_four_oe_n, // oe
  input wire logic [4:0] timer_event_req // requests
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ans; s_req |=> s_ans; endproperty
  a_ans: assert property (p_ans) else $error("ack is not a one-cycle answer");
  property p_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_src: assert property (p_src) else $error("ack without a request");
  property p_dat; wb_dat_o != 32'h0 |-> wb_ack_o; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_rst; $fell(rst) |-> timer_event_req == 5'h00 && timer_waveform_output_oe_n
    && pwm_output_one_oe_n && pwm_output_two_oe_n && pwm_output_three_oe_n
    && pwm_output_four_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("outputs not in reset state");
  property p_oe0; timer_waveform_output_oe_n |-> !timer_waveform_output; endproperty
  a_oe0: assert property (p_oe0) else $error("released pin shows waveform");
  property p_oe14; !((pwm_output_one && pwm_output_one_oe_n)
    || (pwm_output_two && pwm_output_two_oe_n) || (pwm_output_three && pwm_output_three_oe_n)
    || (pwm_output_four && pwm_output_four_oe_n)); endproperty
  a_oe14: assert property (p_oe14) else $error("released pwm pin high");
  // a high time spans at least one 16 MHz tick; checked as 9 or more cycles on pwm_output_one
  property p_pw; $rose(pwm_output_one) |=> (pwm_output_one || pwm_output_one_oe_n)[*8];
  endproperty
  a_pw: assert property (p_pw) else $error("pulse shorter than a tick");
  property p_req; ($past(timer_event_req) & ~timer_event_req) != 5'h00
    |-> $past(wb_ack_o); endproperty
  a_req: assert property (p_req) else $error("request dropped without a write");
endmodule // gtp_asserts
bind gtp_top gtp_asserts u_chk (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_waveform_output(timer_waveform_output),
  .timer_waveform_output_oe_n(timer_waveform_output_oe_n),
  .pwm_output_one(pwm_output_one), .pwm_output_one_oe_n(pwm_output_one_oe_n),
  .pwm_output_two(pwm_output_two), .pwm_output_two_oe_n(pwm_output_two_oe_n),
  .pwm_output_three(pwm_output_three), .pwm_output_three_oe_n(pwm_output_three_oe_n),
  .pwm_output_four(pwm_output_four), .pwm_output_four_oe_n(pwm_output_four_oe_n),
  .timer_event_req(timer_event_req));
`default_nettype wire

/* gtp_chan_if.sv */
// gtp_chan_if: per-timer link between the top, its prescaler and its delta-sigma stage.
// assumes all members are clocked by the same mclk.
`timescale 1ns/1ps
`default_nettype none
interface gtp_chan_if;
  logic base_tick;
  logic [gtp_pkg::PRE_W-1:0] prescale;
  logic tick;
  logic ds_run;
  logic ds_rtz;
  logic [gtp_pkg::CNT_W-1:0] ds_high;
  logic ds_out;
  modport ctl (output base_tick, prescale, ds_run, ds_rtz, ds_high, input tick, ds_out);
  modport pre (input base_tick, prescale, output tick);
  modport dsm (input tick, ds_run, ds_rtz, ds_high, output ds_out);
endinterface
`default_nettype wire

/* gtp_dsm.sv */
// gtp_dsm: delta-sigma pulse stream, nrz or rtz, one tick per pulse.
// assumes tick is a one-cycle pulse of the prescaled timer clock.
`timescale 1ns/1ps
`default_nettype none
module gtp_dsm (
  input wire logic mclk, // system clock
  input wire logic rst,  // synchronous reset
  input wire logic ce,   // clock enable
  gtp_chan_if.dsm ch     // run, mode, level in; pulse out
);
  typedef struct packed {
    logic [gtp_pkg::CNT_W-1:0] pos;
    logic [gtp_pkg::CNT_W-1:0] seed;
    logic phase;
    logic out;
  } gtp_dsm_state_t;

  gtp_dsm_state_t s;
  gtp_dsm_state_t next_s;
  logic [gtp_pkg::CNT_W-1:0] rev;

  always_comb begin
    next_s = s;
    for (int b = 0; b < gtp_pkg::CNT_W; b++) begin
      rev[b] = s.pos[gtp_pkg::CNT_W-1-b];
    end
    if (!ch.ds_run) begin
      next_s.pos = '0;
      next_s.phase = 1'b0;
      next_s.out = 1'b0;
    end else if (ch.tick) begin
      if (ch.ds_rtz && s.phase) begin
        next_s.out = 1'b0;
        next_s.phase = 1'b0;
      end else begin
        // xor with a per-cycle seed permutes slots, so the pulse count stays exact
        next_s.out = (rev ^ s.seed) < ch.ds_high;
        next_s.pos = s.pos + gtp_pkg::CNT_ONE;
        next_s.phase = ch.ds_rtz;
        if (s.pos == gtp_pkg::CNT_MAX) begin
          next_s.seed = {s.seed[gtp_pkg::CNT_W-2:0], ^(s.seed & gtp_pkg::DS_TAPS)};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.seed <= gtp_pkg::DS_SEED_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign ch.ds_out = s.out;
endmodule // gtp_dsm
`default_nettype wire

/* gtp_partner.sv */
// gtp_partner: pulse source standing in for the external gate and capture drivers.
// assumes go is a one-cycle strobe; w of 20 or more keeps edges 100 ns apart.
`timescale 1ns/1ps
`default_nettype none
module gtp_partner (
  input wire logic mclk, // system clock
  input wire logic go, // start a burst
  input wire logic [7:0] n, // pulse count
  input wire logic [7:0] w, // half period in cycles
  output logic pin, // pin level, idle low
  output logic busy // burst running
);
  int k = 0;
  int c = 0;
  initial pin = 1'b0;
  assign busy = (k != 0);
  always @(posedge mclk) begin
    if (go) begin
      k <= 2 * int'(n);
      c <= 1;
      pin <= 1'b1;
    end else if (k != 0) begin
      c <= (c == int'(w)) ? 1 : c + 1;
      if (c == int'(w)) begin
        k <= k - 1;
        pin <= (k > 1) ? ~pin : 1'b0;
      end
    end
  end
endmodule // gtp_partner
`default_nettype wire

/* gtp_pkg.sv */
// gtp_pkg: constants, fields and modes of the timer / pwm unit.
// assumes one 200 MHz clock; the 16 MHz source tick derives from it.
package gtp_pkg;
  localparam int NUM_TIMERS = 5;
  localparam int CNT_W = 16;
  localparam int PRE_W = 5;
  localparam int CTL_W = 14;
  localparam int MCLK_MHZ = 200;
  localparam int SRC_MHZ = 16;
  localparam int BASE_ACC_W = 9;
  localparam logic [BASE_ACC_W-1:0] BASE_INC = BASE_ACC_W'(SRC_MHZ);
  localparam logic [BASE_ACC_W-1:0] BASE_MOD = BASE_ACC_W'(MCLK_MHZ);
  localparam logic [PRE_W-1:0] PRE_MAX = 5'h10;
  // register map: byte address = timer * 0x20 + word * 4
  localparam int ADR_W = 8;
  localparam int TSEL_LSB = 5;
  localparam int RSEL_LSB = 2;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_PRESCALE = 3'h1;
  localparam logic [2:0] REG_RISE = 3'h2;
  localparam logic [2:0] REG_FALL = 3'h3;
  localparam logic [2:0] REG_COUNT = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  // control word fields
  localparam int CTL_RUN = 0;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_SINGLE = 4;
  localparam int CTL_GATE = 5;
  localparam int CTL_EDGE_LSB = 6;
  localparam int CTL_RTZ = 8;
  localparam int CTL_RISE_IE = 9;
  localparam int CTL_FALL_IE = 10;
  localparam int CTL_OUT_EN = 11;
  localparam int CTL_CKG_EN = 12;
  localparam int CTL_CAP_EN = 13;
  localparam int ST_RISE = 0;
  localparam int ST_FALL = 1;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] DS_SEED_RST = 16'hACE1;
  localparam logic [CNT_W-1:0] DS_TAPS = 16'hB400;

  typedef enum logic [2:0] {
    MODE_TIMER = 3'h0,
    MODE_COUNTER = 3'h1,
    MODE_PWM = 3'h2,
    MODE_CAPTURE = 3'h3,
    MODE_DSM = 3'h4
  } gtp_mode_t;

  function automatic logic gtp_reg_hit(input logic [ADR_W-1:0] adr, input int t,
                                       input logic [2:0] r);
    gtp_reg_hit = (adr[ADR_W-1:TSEL_LSB] == 3'(t)) && (adr[TSEL_LSB-1:RSEL_LSB] == r);
  endfunction

  function automatic logic [31:0] gtp_merge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
    gtp_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) gtp_merge[b*8 +: 8] = d[b*8 +: 8];
    end
  endfunction
endpackage

/* gtp_prescale.sv */
// gtp_prescale: divides the 16 MHz base tick by two to the prescale setting.
// assumes base_tick is a one-cycle pulse; tick follows it by one cycle.
`timescale 1ns/1ps
`default_nettype none
module gtp_prescale (
  input wire logic mclk, // system clock
  input wire logic rst,  // synchronous reset
  input wire logic ce,   // clock enable
  gtp_chan_if.pre ch     // prescale setting in, tick out
);
  typedef struct packed {
    logic [gtp_pkg::CNT_W-1:0] cnt;
    logic tick;
  } gtp_pre_state_t;

  gtp_pre_state_t s;
  gtp_pre_state_t next_s;
  logic [gtp_pkg::PRE_W-1:0] eff;
  logic [gtp_pkg::CNT_W-1:0] lim;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    // settings above 16 clamp
    eff = (ch.prescale > gtp_pkg::PRE_MAX) ? gtp_pkg::PRE_MAX : ch.prescale;
    lim = gtp_pkg::CNT_W'((17'h00001 << eff) - 17'h00001);
    if (ch.base_tick) begin
      if (eff == '0) begin
        next_s.tick = 1'b1;
      end else if (s.cnt >= lim) begin
        next_s.tick = 1'b1;
        next_s.cnt = '0;
      end else begin
        next_s.cnt = s.cnt + gtp_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign ch.tick = s.tick;
endmodule // gtp_prescale
`default_nettype wire

/* gtp_top.sv */
// gtp_top: general timer plus four pwm-only timers behind a wishbone slave.
// assumes pins synchronous to mclk and a classic single-cycle bus master.
//
// Operation
// - Timer source is a 16 MHz tick from the system clock.
// - Prescale zero passes source tick; 1..16 divides by two to that power.
// - Each timer: 16-bit up-counter, rise and fall compare registers.
// - Gating on: timer 0 holds its count while the gate pin is high.
// - Counter equal to rise or fall value can raise a request.
// - PWM output rises on rise match and falls on fall match.
// - PWM: single-shot pulse or continuous train of programmed period.
// - Continuous mode clears the counter at fall match and restarts.
// - New rise and fall values apply only after the current cycle.
// - Waveform drives its pin only while that output driver is enabled.
// - Capture copies counter to rise on rising edges, fall on falling edges.
// - Captures count from start; later edges overwrite earlier values.
// - Reading the capture registers stops the counter.
// - Timer mode runs once or repeatedly, fall match flags at period value.
// - Event counter counts gate-pin edges, flags at the fall count.
// - Event edges selectable: rising only, falling only, or both.
// - Each delta-sigma pulse lasts exactly one timer clock period.
// - NRZ delta-sigma: high for the high-register count of clocks per 2^16.
// - Delta-sigma pulses pseudo-randomly spread and differ cycle to cycle.
// - RTZ delta-sigma: low every other clock, conversion lasts 2^17 clocks.
// - PWM-only timers lack counter and capture modes and external gating.
// - Each external timer pin has its own enable.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gtp_top (
  input wire logic mclk,                    // system clock, 200 MHz
  input wire logic rst,                     // synchronous reset, active high
  input wire logic ce,                      // clock enable, freezes all state when low
  input wire logic wb_cyc_i,                // wishbone cycle
  input wire logic wb_stb_i,                // wishbone strobe
  input wire logic wb_we_i,                 // wishbone write enable
  input wire logic [7:0] wb_adr_i,          // wishbone byte address
  input wire logic [3:0] wb_sel_i,          // wishbone byte selects
  input wire logic [31:0] wb_dat_i,         // wishbone write data
  output logic [31:0] wb_dat_o,             // wishbone read data
  output logic wb_ack_o,                    // wishbone acknowledge
  input wire logic timer_clock_gate_input,  // event clock or gate pin
  input wire logic timer_capture_input,     // capture pin
  output logic timer_waveform_output,       // general timer waveform
  output logic timer_waveform_output_oe_n,  // low while driving
  output logic pwm_output_one,              // pwm timer 1
  output logic pwm_output_one_oe_n,         // low while driving
  output logic pwm_output_two,              // pwm timer 2
  output logic pwm_output_two_oe_n,         // low while driving
  output logic pwm_output_three,            // pwm timer 3
  output logic pwm_output_three_oe_n,       // low while driving
  output logic pwm_output_four,             // pwm timer 4
  output logic pwm_output_four_oe_n,        // low while driving
  output logic [4:0] timer_event_req        // per-timer request, any enabled flag set
);
  localparam int NT = gtp_pkg::NUM_TIMERS;
  localparam int CW = gtp_pkg::CNT_W;

  typedef struct packed {
    logic [gtp_pkg::BASE_ACC_W-1:0] base_acc;
    logic base_tick;
    logic [NT-1:0][gtp_pkg::CTL_W-1:0] ctrl;
    logic [NT-1:0][gtp_pkg::PRE_W-1:0] pre;
    logic [NT-1:0][CW-1:0] rise;
    logic [NT-1:0][CW-1:0] fall;
    logic [NT-1:0][CW-1:0] rise_act;
    logic [NT-1:0][CW-1:0] fall_act;
    logic [NT-1:0][CW-1:0] count;
    logic [NT-1:0] run;
    logic [NT-1:0] wave;
    logic [NT-1:0] pin;
    logic [NT-1:0] pin_oe_n;
    logic [NT-1:0] st_rise;
    logic [NT-1:0] st_fall;
    logic [NT-1:0] req;
    logic gate_q;
    logic cap_q;
    logic ack;
    logic [31:0] rdata;
  } gtp_top_state_t;

  gtp_top_state_t s;
  gtp_top_state_t next_s;

  logic [NT-1:0] pre_tick;
  logic [NT-1:0] ds_out;
  logic [gtp_pkg::BASE_ACC_W-1:0] acc_sum;
  logic hit;
  logic mapped;
  logic wr_now;
  logic rd_now;
  logic [2:0] tsel;
  logic [2:0] rsel;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  gtp_pkg::gtp_mode_t mode;
  logic [gtp_pkg::CTL_W-1:0] c;
  logic tick;
  logic gated;
  logic gate_in;
  logic cap_in;
  logic ev_rise;
  logic ev_fall;
  logic rm;
  logic fm;
  logic [CW-1:0] nc;
  logic [1:0] edge_sel;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_chan
      gtp_chan_if ch ();
      assign ch.base_tick = s.base_tick;
      assign ch.prescale = s.pre[gi];
      assign ch.ds_run = s.run[gi] && (s.ctrl[gi][gtp_pkg::CTL_MODE_LSB +: 3] ==
                                       gtp_pkg::MODE_DSM);
      assign ch.ds_rtz = s.ctrl[gi][gtp_pkg::CTL_RTZ];
      assign ch.ds_high = s.rise[gi];
      assign pre_tick[gi] = ch.tick;
      assign ds_out[gi] = ch.ds_out;
      gtp_prescale u_pre (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .ch(ch)
      );
      gtp_dsm u_dsm (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .ch(ch)
      );
    end
  endgenerate

  always_comb begin
    next_s = s;
    mode = gtp_pkg::MODE_TIMER;
    c = '0;
    tick = 1'b0;
    gated = 1'b0;
    rm = 1'b0;
    fm = 1'b0;
    nc = '0;
    edge_sel = '0;
    wr_word = '0;
    // 16 base ticks per 200 clocks, spaced 12 or 13 apart
    acc_sum = s.base_acc + gtp_pkg::BASE_INC;
    next_s.base_tick = 1'b0;
    if (acc_sum >= gtp_pkg::BASE_MOD) begin
      next_s.base_acc = acc_sum - gtp_pkg::BASE_MOD;
      next_s.base_tick = 1'b1;
    end else begin
      next_s.base_acc = acc_sum;
    end

    // ack one cycle after the request; writes land at the ack edge
    hit = wb_cyc_i && wb_stb_i;
    tsel = wb_adr_i[gtp_pkg::ADR_W-1:gtp_pkg::TSEL_LSB];
    rsel = wb_adr_i[gtp_pkg::TSEL_LSB-1:gtp_pkg::RSEL_LSB];
    mapped = (tsel < 3'(NT)) && (rsel <= gtp_pkg::REG_STATUS);
    wr_now = hit && s.ack && wb_we_i && mapped;
    rd_now = hit && s.ack && !wb_we_i && mapped;
    next_s.ack = hit && !s.ack;
    rd_word = '0;
    if (hit && !s.ack && !wb_we_i && mapped) begin
      unique case (rsel)
        gtp_pkg::REG_CTRL: begin
          rd_word = 32'(s.ctrl[tsel]);
          rd_word[gtp_pkg::CTL_RUN] = s.run[tsel];
        end
        gtp_pkg::REG_PRESCALE: rd_word = 32'(s.pre[tsel]);
        gtp_pkg::REG_RISE: rd_word = 32'(s.rise[tsel]);
        gtp_pkg::REG_FALL: rd_word = 32'(s.fall[tsel]);
        gtp_pkg::REG_COUNT: rd_word = 32'(s.count[tsel]);
        default: rd_word = 32'({s.st_fall[tsel], s.st_rise[tsel]});
      endcase
    end
    next_s.rdata = rd_word;

    next_s.gate_q = timer_clock_gate_input;
    next_s.cap_q = timer_capture_input;
    // input pins reach timer 0 only, each behind its enable
    gate_in = s.ctrl[0][gtp_pkg::CTL_CKG_EN] && timer_clock_gate_input;
    cap_in = s.ctrl[0][gtp_pkg::CTL_CAP_EN] && timer_capture_input;

    for (int t = 0; t < NT; t++) begin
      c = s.ctrl[t];
      mode = gtp_pkg::gtp_mode_t'(c[gtp_pkg::CTL_MODE_LSB +: 3]);
      edge_sel = c[gtp_pkg::CTL_EDGE_LSB +: 2];
      ev_rise = gate_in && !(s.gate_q && c[gtp_pkg::CTL_CKG_EN]);
      ev_fall = !gate_in && s.gate_q && c[gtp_pkg::CTL_CKG_EN];
      if (mode == gtp_pkg::MODE_COUNTER) begin
        tick = (t == 0) && (((edge_sel == gtp_pkg::EDGE_RISE) && ev_rise) ||
                            ((edge_sel == gtp_pkg::EDGE_FALL) && ev_fall) ||
                            ((edge_sel == gtp_pkg::EDGE_BOTH) && (ev_rise || ev_fall)));
      end else begin
        tick = pre_tick[t];
      end
      gated = (t == 0) && c[gtp_pkg::CTL_GATE] && gate_in && (mode != gtp_pkg::MODE_COUNTER);
      rm = 1'b0;
      fm = 1'b0;
      nc = s.count[t] + gtp_pkg::CNT_ONE;
      if (s.run[t] && tick && !gated) begin
        unique case (mode)
          gtp_pkg::MODE_COUNTER: begin
            rm = (nc == s.rise_act[t]);
            fm = (nc == s.fall_act[t]);
            next_s.count[t] = nc;
            if (fm) begin
              if (c[gtp_pkg::CTL_SINGLE]) begin
                next_s.run[t] = 1'b0;
              end else begin
                next_s.count[t] = '0;
              end
            end
          end
          gtp_pkg::MODE_CAPTURE: begin
            if (t == 0) next_s.count[t] = nc;
          end
          gtp_pkg::MODE_TIMER, gtp_pkg::MODE_PWM: begin
            rm = (s.count[t] == s.rise_act[t]);
            fm = (s.count[t] == s.fall_act[t]);
            if (rm) next_s.wave[t] = 1'b1;
            if (fm) begin
              next_s.wave[t] = 1'b0;
              if (c[gtp_pkg::CTL_SINGLE]) begin
                next_s.run[t] = 1'b0;
              end else begin
                next_s.count[t] = '0;
                next_s.rise_act[t] = s.rise[t];
                next_s.fall_act[t] = s.fall[t];
              end
            end else begin
              next_s.count[t] = nc;
            end
          end
          default: begin
          end
        endcase
      end
      // software writes below win over capture
      if ((t == 0) && s.run[t] && (mode == gtp_pkg::MODE_CAPTURE)) begin
        if (cap_in && !(s.cap_q && c[gtp_pkg::CTL_CAP_EN])) next_s.rise[t] = s.count[t];
        if (!cap_in && s.cap_q && c[gtp_pkg::CTL_CAP_EN]) next_s.fall[t] = s.count[t];
        if (rd_now && (gtp_pkg::gtp_reg_hit(wb_adr_i, t, gtp_pkg::REG_RISE) ||
                       gtp_pkg::gtp_reg_hit(wb_adr_i, t, gtp_pkg::REG_FALL))) begin
          next_s.run[t] = 1'b0;
        end
      end

      if (wr_now && gtp_pkg::gtp_reg_hit(wb_adr_i, t, gtp_pkg::REG_CTRL)) begin
        wr_word = gtp_pkg::gtp_merge(32'(s.ctrl[t]), wb_dat_i, wb_sel_i);
        next_s.ctrl[t] = wr_word[gtp_pkg::CTL_W-1:0];
        if (t != 0) begin
          next_s.ctrl[t][gtp_pkg::CTL_GATE] = 1'b0;
          next_s.ctrl[t][gtp_pkg::CTL_CKG_EN] = 1'b0;
          next_s.ctrl[t][gtp_pkg::CTL_CAP_EN] = 1'b0;
        end
        next_s.run[t] = wr_word[gtp_pkg::CTL_RUN];
        if (wr_word[gtp_pkg::CTL_RUN]) begin
          next_s.count[t] = '0;
          next_s.wave[t] = 1'b0;
          next_s.rise_act[t] = s.rise[t];
          next_s.fall_act[t] = s.fall[t];
        end
      end
      if (wr_now && gtp_pkg::gtp_reg_hit(wb_adr_i, t, gtp_pkg::REG_PRESCALE)) begin
        wr_word = gtp_pkg::gtp_merge(32'(s.pre[t]), wb_dat_i, wb_sel_i);
        next_s.pre[t] = wr_word[gtp_pkg::PRE_W-1:0];
      end
      if (wr_now && gtp_pkg::gtp_reg_hit(wb_adr_i, t, gtp_pkg::REG_RISE)) begin
        wr_word = gtp_pkg::gtp_merge(32'(s.rise[t]), wb_dat_i, wb_sel_i);
        next_s.rise[t] = wr_word[CW-1:0];
      end
      if (wr_now && gtp_pkg::gtp_reg_hit(wb_adr_i, t, gtp_pkg::REG_FALL)) begin
        wr_word = gtp_pkg::gtp_merge(32'(s.fall[t]), wb_dat_i, wb_sel_i);
        next_s.fall[t] = wr_word[CW-1:0];
      end
      // write one to clear; a same-cycle match wins
      wr_word = '0;
      if (wr_now && gtp_pkg::gtp_reg_hit(wb_adr_i, t, gtp_pkg::REG_STATUS)) begin
        wr_word = wb_sel_i[0] ? wb_dat_i : '0;
      end
      next_s.st_rise[t] = (s.st_rise[t] && !wr_word[gtp_pkg::ST_RISE]) ||
                          (rm && c[gtp_pkg::CTL_RISE_IE]);
      next_s.st_fall[t] = (s.st_fall[t] && !wr_word[gtp_pkg::ST_FALL]) ||
                          (fm && c[gtp_pkg::CTL_FALL_IE]);
      next_s.req[t] = next_s.st_rise[t] || next_s.st_fall[t];

      // released pin reads low
      next_s.pin_oe_n[t] = !c[gtp_pkg::CTL_OUT_EN];
      if (!c[gtp_pkg::CTL_OUT_EN]) begin
        next_s.pin[t] = 1'b0;
      end else if (mode == gtp_pkg::MODE_DSM) begin
        next_s.pin[t] = ds_out[t];
      end else begin
        next_s.pin[t] = s.wave[t];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.pin_oe_n <= '1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign timer_waveform_output = s.pin[0];
  assign timer_waveform_output_oe_n = s.pin_oe_n[0];
  assign pwm_output_one = s.pin[1];
  assign pwm_output_one_oe_n = s.pin_oe_n[1];
  assign pwm_output_two = s.pin[2];
  assign pwm_output_two_oe_n = s.pin_oe_n[2];
  assign pwm_output_three = s.pin[3];
  assign pwm_output_three_oe_n = s.pin_oe_n[3];
  assign pwm_output_four = s.pin[4];
  assign pwm_output_four_oe_n = s.pin_oe_n[4];
  assign timer_event_req = s.req;
endmodule // gtp_top
`default_nettype wire

/* testbench.sv */
// testbench: drives gtp_top over wishbone and its pins via two pulse sources.
// assumes the register layout of gtp_top; ce stays high.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q;} gtp_row_t;
  gtp_row_t rows [7] = '{'{8'h04, 32'hFF, 32'h1F}, '{8'h08, 32'h3, 32'h3},
    '{8'h4C, 32'hFFFF1234, 32'h1234}, '{8'h30, 32'h5555, 32'h0}, '{8'h38, 32'hFFFF, 32'h0},
    '{8'hA8, 32'hFFFF, 32'h0}, '{8'h20, 32'h3E20, 32'hE00}};
  logic [31:0] pre [2] = '{32'h0, 32'h2};
  logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, b_n = 8'h00, b_w = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rd, v, r;
  logic g_go = 1'b0, c_go = 1'b0;
  logic ack, wo, wo_n, p1, p1n, p2, p2n, p3, p3n, p4, p4n, gate, cap, g_busy, c_busy;
  logic [4:0] req;
  int errors = 0;
  int n_checks = 0;
  int n, h1, h2, e, t;
  gtp_partner u_gate (.mclk(mclk), .go(g_go), .n(b_n), .w(b_w), .pin(gate), .busy(g_busy));
  gtp_partner u_cap (.mclk(mclk), .go(c_go), .n(b_n), .w(b_w), .pin(cap), .busy(c_busy));
  gtp_top u_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .timer_clock_gate_input(gate), .timer_capture_input(cap),
    .timer_waveform_output(wo), .timer_waveform_output_oe_n(wo_n),
    .pwm_output_one(p1), .pwm_output_one_oe_n(p1n), .pwm_output_two(p2),
    .pwm_output_two_oe_n(p2n), .pwm_output_three(p3), .pwm_output_three_oe_n(p3n),
    .pwm_output_four(p4), .pwm_output_four_oe_n(p4n), .timer_event_req(req));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int c, input int lim);
    if (c >= lim) begin
      errors++;
      conclude();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hF};
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    v = rd;
    {cyc, stb} <= 2'b00;
    @(posedge mclk);
    tmo(i, 20);
  endtask
  task automatic burst(input logic s, input logic [7:0] k, input logic [7:0] w, input logic wt);
    int i;
    {b_n, b_w, g_go, c_go} <= {k, w, !s, s};
    @(posedge mclk);
    {g_go, c_go} <= 2'b00;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (wt && (g_busy | c_busy) !== 1'b0 && i < 3000);
    tmo(i, 3000);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(32'({req, wo, p1, p2, p3, p4, wo_n, p1n, p2n, p3n, p4n}), 32'h1F);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].a, rows[i].d);
      wb(1'b0, rows[i].a, 32'h0);
      chk(v, rows[i].q);
    end
    $display("test registers done");
    foreach (pre[j]) begin
      wb(1'b1, 8'h04, pre[j]);
      wb(1'b1, 8'h0C, 32'h9);
      wb(1'b1, 8'h00, 32'h411);
      n = 0;
      while (req[0] !== 1'b1 && n < 2000) begin
        @(posedge mclk);
        n++;
      end
      tmo(n, 2000);
      e = 125 << pre[j];
      t = (13 << pre[j]) + 5;
      chk(32'(n > e - t && n < e + t), 32'h1);
      wb(1'b0, 8'h14, 32'h0);
      chk(v, 32'h2);
      wb(1'b0, 8'h10, 32'h0);
      chk(v, 32'h9);
      wb(1'b1, 8'h14, 32'h3);
      repeat (3) @(posedge mclk);
      chk(32'(req), 32'h0);
    end
    $display("test timer done");
    wb(1'b1, 8'h28, 32'h2);
    wb(1'b1, 8'h2C, 32'h5);
    wb(1'b1, 8'h20, 32'h805);
    wb(1'b1, 8'h48, 32'hFFFF);
    wb(1'b1, 8'h40, 32'h909);
    repeat (100) @(posedge mclk);
    {h1, h2} = 64'h0;
    repeat (1500) begin
      @(posedge mclk);
      h1 += int'(p1);
      h2 += int'(p2);
    end
    chk(32'(h1 > 720 && h1 < 780), 32'h1);
    chk(32'(h2 > 690 && h2 < 810), 32'h1);
    chk(32'({p1n, p3n}), 32'h1);
    wb(1'b1, 8'h20, 32'h0);
    repeat (2) @(posedge mclk);
    chk(32'({p1n, p1}), 32'h2);
    $display("test pwm done");
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h00, 32'h2007);
    burst(1'b1, 8'h02, 8'h64, 1'b1);
    wb(1'b0, 8'h08, 32'h0);
    r = v;
    wb(1'b0, 8'h0C, 32'h0);
    chk(32'((v - r) > 6 && (v - r) < 10 && r > 14), 32'h1);
    wb(1'b0, 8'h10, 32'h0);
    r = v;
    repeat (50) @(posedge mclk);
    wb(1'b0, 8'h10, 32'h0);
    chk(v, r);
    $display("test capture done");
    wb(1'b1, 8'h0C, 32'h4);
    for (int s = 1; s < 4; s++) begin
      wb(1'b1, 8'h14, 32'h3);
      wb(1'b1, 8'h00, 32'h1413 | (32'(s) << 6));
      burst(1'b0, (s == 3) ? 8'h01 : 8'h03, 8'h14, 1'b1);
      chk(32'(req), 32'h0);
      burst(1'b0, 8'h01, 8'h14, 1'b1);
      repeat (4) @(posedge mclk);
      chk(32'(req), 32'h1);
    end
    $display("test counter done");
    wb(1'b1, 8'h0C, 32'hFFFF);
    burst(1'b0, 8'h01, 8'hFA, 1'b0);
    wb(1'b1, 8'h00, 32'h1021);
    repeat (50) @(posedge mclk);
    wb(1'b0, 8'h10, 32'h0);
    chk(v, 32'h0);
    repeat (250) @(posedge mclk);
    wb(1'b0, 8'h10, 32'h0);
    chk(32'(v != 32'h0), 32'h1);
    $display("test gate done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
